// ==== rtl/scr_serial_port.sv ====
// serial configuration port with readback and daisy chain, apb status
// assumes sclk stands still outside frames and latch_strobe stays
// high at least six clock cycles between frames
// Contract
// - disabled mixer: standby bit picks off or low-power
// - mixer bias reference always stays powered
// - readback pointer is register five top nibble
// - pointer always names register zero to fifteen
// - readback uses pointer from before current write
// - new pointer data appears on next write
// - all-zero word changes nothing, still shifts out
// - latch strobe serves as chip select
// - word committed on latch strobe rising edge
// - register six bit twenty enables chaining
// - chain: readback and data pass device by device
// - low nibble of each word selects register
// - register thirteen bits five, four enable mixers
`include "scr_regs.svh"

module scr_serial_port #(
	parameter int WORD_W = 32,
	parameter int NREG   = 16
) (
	input  wire logic         clock,          // system clock, 40 mhz
	input  wire logic         rst_n,          // async reset, active low
	input  scr_pkg::scr_apb_req_t apb_req,    // apb request group
	output scr_pkg::scr_apb_rsp_t apb_rsp,    // apb answer group
	input  wire logic         sclk,           // serial clock, link domain
	input  wire logic         sdata_in,       // serial data in
	input  wire logic         latch_strobe,   // frame strobe, low in frame
	output logic              serial_out_pin, // serial data out
	output scr_pkg::scr_mix_t mixer_ctl       // mixer power controls
);
	import scr_pkg::*;

	// the word format is fixed by the field positions
	if (WORD_W != 32 || NREG != 16) begin : g_bad_param
		$error("scr_serial_port: only 32-bit words, 16 registers");
	end

	// ***************************************
	// serial clock domain
	// ***************************************
	logic [5:0]        bit_cnt_q, bit_cnt_d;
	logic [WORD_W-1:0] shift_q, shift_d;
	logic              sdo_q, sdo_d;
	logic              full_q, full_d;
	logic [WORD_W-1:0] rb_word_q, rb_word_d;
	logic              chain_q, chain_d;
	logic              frame_rst_n;

	// strobe high holds the counter, so each frame starts at bit zero
	assign frame_rst_n = rst_n & ~latch_strobe;

	// shift path; rb_word_q and chain_q stay frozen while the strobe
	// is low, which is what makes sampling them here safe
	always_comb begin
		bit_cnt_d = bit_cnt_q;
		shift_d   = shift_q;
		sdo_d     = sdo_q;
		full_d    = full_q;
		if (!latch_strobe) begin
			if (bit_cnt_q == 6'd0) begin
				shift_d = {rb_word_q[WORD_W-2:0], sdata_in};
				sdo_d   = rb_word_q[WORD_W-1];
				full_d  = 1'b0;
			end else begin
				shift_d = {shift_q[WORD_W-2:0], sdata_in};
				if (chain_q || bit_cnt_q < `SCR_WORD_BITS) begin
					sdo_d = shift_q[WORD_W-1];
				end else begin
					sdo_d = 1'b0;
				end
			end
			if (bit_cnt_q < `SCR_CNT_SAT) begin
				bit_cnt_d = bit_cnt_q + 6'd1;
			end
			if (bit_cnt_q == `SCR_WORD_BITS - 6'd1) begin
				full_d = 1'b1;
			end
		end
	end

	// bit counter, cleared while the strobe is high
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_q <= 6'd0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
		end
	end

	// shift register and output; last 32 bits in form the word
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
			sdo_q   <= 1'b0;
			full_q  <= 1'b0;
		end else begin
			shift_q <= shift_d;
			sdo_q   <= sdo_d;
			full_q  <= full_d;
		end
	end

	assign serial_out_pin = sdo_q;

	// ***************************************
	// strobe synchroniser
	// ***************************************
	logic le_meta_q, le_sync_q, le_prev_q;
	logic le_rise;

	// strobe idles high, so reset to high avoids a false rise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			le_meta_q <= 1'b1;
			le_sync_q <= 1'b1;
			le_prev_q <= 1'b1;
		end else begin
			le_meta_q <= latch_strobe;
			le_sync_q <= le_meta_q;
			le_prev_q <= le_sync_q;
		end
	end

	assign le_rise = le_sync_q & ~le_prev_q;

	// ***************************************
	// commit and readback sequencer
	// ***************************************
	scr_state_t        state_q, state_d;
	logic [3:0]        ptr_q, ptr_d;
	logic              mix_a_q, mix_a_d, mix_b_q, mix_b_d;
	logic              stby_q, stby_d;
	logic [WORD_W-1:0] last_q, last_d;
	logic [15:0]       ncommit_q, ncommit_d;
	scr_mix_t          mix_q, mix_d;
	logic              ctrl_en_q, ctrl_en_d;
	logic              commit;
	logic [3:0]        sel;
	logic [WORD_W-1:0] mem_rdata;

	// shift_q and full_q are static once the strobe has risen
	assign sel = shift_q[`SCR_SEL_MSB:0];
	assign commit = le_rise & full_q & ctrl_en_q
		& (shift_q != `SCR_NOP_WORD);

	// next-state and shadow field decode
	always_comb begin
		state_d   = state_q;
		ptr_d     = ptr_q;
		chain_d   = chain_q;
		mix_a_d   = mix_a_q;
		mix_b_d   = mix_b_q;
		stby_d    = stby_q;
		last_d    = last_q;
		ncommit_d = ncommit_q;
		rb_word_d = rb_word_q;
		unique case (state_q)
			SCR_IDLE: begin
				if (commit) begin
					last_d    = shift_q;
					ncommit_d = ncommit_q + 16'd1;
					if (sel == `SCR_PTR_REG) begin
						ptr_d = shift_q[`SCR_PTR_MSB:`SCR_PTR_LSB];
					end
					if (sel == `SCR_CHAIN_REG) begin
						chain_d = shift_q[`SCR_CHAIN_BIT];
					end
					if (sel == `SCR_MIX_REG) begin
						mix_a_d = shift_q[`SCR_MIXA_BIT];
						mix_b_d = shift_q[`SCR_MIXB_BIT];
					end
					if (sel == `SCR_STBY_REG) begin
						stby_d = shift_q[`SCR_STBY_BIT];
					end
					state_d = SCR_FETCH;
				end
			end
			SCR_FETCH: begin
				state_d = SCR_LOAD;
			end
			SCR_LOAD: begin
				rb_word_d = mem_rdata;
				state_d   = SCR_IDLE;
			end
			default: begin
				state_d = SCR_IDLE;
			end
		endcase
	end

	always_comb begin
		mix_d.bias_on = 1'b1;
		mix_d.chan_a  = mix_a_d ? SCR_MIX_ON
			: (stby_d ? SCR_MIX_STBY : SCR_MIX_OFF);
		mix_d.chan_b  = mix_b_d ? SCR_MIX_ON
			: (stby_d ? SCR_MIX_STBY : SCR_MIX_OFF);
	end

	// reset starts in fetch so the first readback word is defined
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= SCR_FETCH;
			ptr_q     <= 4'h0;
			chain_q   <= 1'b0;
			mix_a_q   <= 1'b0;
			mix_b_q   <= 1'b0;
			stby_q    <= 1'b0;
			last_q    <= '0;
			ncommit_q <= 16'h0000;
			rb_word_q <= '0;
			mix_q     <= '{SCR_MIX_OFF, SCR_MIX_OFF, 1'b1};
		end else begin
			state_q   <= state_d;
			ptr_q     <= ptr_d;
			chain_q   <= chain_d;
			mix_a_q   <= mix_a_d;
			mix_b_q   <= mix_b_d;
			stby_q    <= stby_d;
			last_q    <= last_d;
			ncommit_q <= ncommit_d;
			rb_word_q <= rb_word_d;
			mix_q     <= mix_d;
		end
	end

	assign mixer_ctl = mix_q;

	scr_cfg_mem #(.DEPTH(NREG), .WIDTH(WORD_W), .AW(4)) u_mem (
		.clock (clock),
		.rst_n (rst_n),
		.we    (commit && state_q == SCR_IDLE),
		.waddr (sel),
		.wdata (shift_q),
		.raddr (ptr_q),
		.rdata (mem_rdata)
	);

	// ***************************************
	// apb slave
	// ***************************************
	logic [31:0] prdata_q, prdata_d;
	logic        perr_q, perr_d;
	logic        setup, access;

	assign setup  = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable;

	// read data is prepared in setup so it can leave a flop
	always_comb begin
		prdata_d  = prdata_q;
		perr_d    = perr_q;
		ctrl_en_d = ctrl_en_q;
		if (setup) begin
			perr_d   = 1'b0;
			prdata_d = 32'h0000_0000;
			unique case (apb_req.paddr)
				`SCR_CTRL_OFS:   prdata_d[0] = ctrl_en_q;
				`SCR_STATUS_OFS: prdata_d = {ncommit_q, 10'h000,
					state_q != SCR_IDLE, chain_q, ptr_q};
				`SCR_LAST_OFS:   prdata_d = last_q;
				default:         perr_d = 1'b1;
			endcase
		end
		if (access && apb_req.pwrite && apb_req.paddr == `SCR_CTRL_OFS) begin
			ctrl_en_d = apb_req.pwdata[0];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q  <= 32'h0000_0000;
			perr_q    <= 1'b0;
			ctrl_en_q <= `SCR_CTRL_RST;
		end else begin
			prdata_q  <= prdata_d;
			perr_q    <= perr_d;
			ctrl_en_q <= ctrl_en_d;
		end
	end

	// one wait-free access phase after each setup
	assign apb_rsp.pready  = access;
	assign apb_rsp.pslverr = access & perr_q;
	assign apb_rsp.prdata  = prdata_q;

	// ***************************************
	// assertions and covers
	// ***************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_nop_ignored: assert property (
		le_rise && shift_q == `SCR_NOP_WORD |-> !u_mem.we ##1 $stable(ptr_q))
		else $error("nop word wrote a register");
	a_commit_edge: assert property (
		u_mem.we |-> le_rise && full_q)
		else $error("register written without strobe rise");
	a_sel_field: assert property (
		u_mem.we |=> u_mem.mem_q[$past(sel)] == $past(shift_q))
		else $error("word stored at wrong register");
	a_ptr_load: assert property (
		u_mem.we && sel == `SCR_PTR_REG
		|=> ptr_q == $past(shift_q[`SCR_PTR_MSB:`SCR_PTR_LSB]))
		else $error("pointer not taken from register five");
	a_chain_load: assert property (
		u_mem.we && sel == `SCR_CHAIN_REG
		|=> chain_q == $past(shift_q[`SCR_CHAIN_BIT]))
		else $error("chain enable not taken from bit twenty");
	a_mix_enable: assert property (
		u_mem.we && sel == `SCR_MIX_REG
		|=> ##1 (mixer_ctl.chan_a == SCR_MIX_ON)
			== $past(shift_q[`SCR_MIXA_BIT], 2))
		else $error("mixer a enable not from bit five");
	a_mix_standby: assert property (
		!mix_a_q && stby_q |-> mixer_ctl.chan_a == SCR_MIX_STBY)
		else $error("disabled mixer ignored standby select");
	a_bias_kept: assert property (
		mixer_ctl.chan_a == SCR_MIX_OFF |-> mixer_ctl.bias_on)
		else $error("bias reference dropped");
	a_rb_refresh: assert property (
		u_mem.we |=> state_q == SCR_FETCH ##1 state_q == SCR_LOAD
		##1 rb_word_q == u_mem.mem_q[ptr_q])
		else $error("readback word not refreshed after commit");
	a_rb_stable: assert property (
		!le_sync_q && !le_prev_q |-> $stable(rb_word_q))
		else $error("readback word moved inside a frame");

	a_sdo_lead: assert property (
		@(posedge sclk) disable iff (!rst_n || latch_strobe)
		bit_cnt_q == 6'd0 |=> sdo_q == $past(rb_word_q[WORD_W-1]))
		else $error("frame did not lead with readback msb");
	a_chain_delay: assert property (
		@(posedge sclk) disable iff (!rst_n || latch_strobe)
		chain_q && bit_cnt_q >= `SCR_WORD_BITS
		|=> sdo_q == $past(sdata_in, 33))
		else $error("chain output not delayed by 32 clocks");
	a_word_full: assert property (
		@(posedge sclk) disable iff (!rst_n || latch_strobe)
		bit_cnt_q == `SCR_WORD_BITS - 6'd1 |=> full_q)
		else $error("word not complete after 32 bits");

	c_nop_frame: cover property (le_rise && full_q && shift_q == '0);
	c_ptr_write: cover property (u_mem.we && sel == `SCR_PTR_REG);
	c_chain_long: cover property (@(posedge sclk)
		chain_q && bit_cnt_q == `SCR_CNT_SAT);
	c_apb_error: cover property (apb_rsp.pslverr);

endmodule

// ==== rtl/scr_regs.svh ====
// offsets, field positions, reset values and counts of the serial
// configuration port; assumes 12-bit apb byte addresses, 32-bit data
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// ***************************************
// apb register map (byte addresses)
// ***************************************
`define SCR_CTRL_OFS    12'h000
`define SCR_STATUS_OFS  12'h004
`define SCR_LAST_OFS    12'h008
`define SCR_CTRL_RST    1'b1

// ***************************************
// serial word layout
// ***************************************
`define SCR_SEL_MSB     3
`define SCR_PTR_REG     4'h5
`define SCR_PTR_MSB     31
`define SCR_PTR_LSB     28
`define SCR_CHAIN_REG   4'h6
`define SCR_CHAIN_BIT   20
`define SCR_MIX_REG     4'hd
`define SCR_MIXA_BIT    5
`define SCR_MIXB_BIT    4
`define SCR_STBY_REG    4'hf
`define SCR_STBY_BIT    14
`define SCR_NOP_WORD    32'h0000_0000

// ***************************************
// serial counts
// ***************************************
`define SCR_WORD_BITS   6'd32
`define SCR_CNT_SAT     6'd33

`endif

// ==== rtl/scr_pkg.sv ====
// types shared by the serial configuration port
// assumes scr_regs.svh supplies the numeric constants
package scr_pkg;

	// sequencer after a strobe rise
	typedef enum logic [1:0] {
		SCR_IDLE  = 2'b00,
		SCR_FETCH = 2'b01,
		SCR_LOAD  = 2'b10
	} scr_state_t;

	// per-channel mixer power state
	typedef enum logic [1:0] {
		SCR_MIX_OFF  = 2'b00,
		SCR_MIX_STBY = 2'b01,
		SCR_MIX_ON   = 2'b10
	} scr_mix_mode_t;

	typedef struct packed {
		scr_mix_mode_t chan_a;
		scr_mix_mode_t chan_b;
		logic          bias_on;
	} scr_mix_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} scr_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} scr_apb_rsp_t;

endpackage

// ==== rtl/scr_cfg_mem.sv ====
// register file of the serial port: one write, one registered read
// assumes a single clock; contents clear under reset
module scr_cfg_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 32,
	parameter int AW    = 4
) (
	input  wire logic             clock,  // system clock
	input  wire logic             rst_n,  // async reset, active low
	input  wire logic             we,     // write strobe
	input  wire logic [AW-1:0]    waddr,  // write index
	input  wire logic [WIDTH-1:0] wdata,  // write word
	input  wire logic [AW-1:0]    raddr,  // read index
	output logic      [WIDTH-1:0] rdata   // read word, one cycle late
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rdata_q;

	// depth must fill the index exactly
	if (DEPTH != (1 << AW)) begin : g_bad_depth
		$error("scr_cfg_mem: DEPTH must equal 2**AW");
	end

	// storage and read register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			rdata_q <= '0;
		end else begin
			if (we) begin
				mem_q[waddr] <= wdata;
			end
			rdata_q <= mem_q[raddr];
		end
	end

	assign rdata = rdata_q;

endmodule

// ==== sim/scr_ctl_model.sv ====
// behavioural serial controller facing the configuration port
// assumes the bench calls frame() one at a time from one process
module scr_ctl_model (
	output logic      sclk,           // link clock, still between frames
	output logic      sdata_in,       // serial data to the port
	output logic      latch_strobe,   // frame strobe, low in a frame
	input  wire logic serial_out_pin  // readback from the port
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle line levels at time zero
	initial begin
		sclk = 1'b0;
		sdata_in = 1'b0;
		latch_strobe = 1'b1;
	end

	// msb first, strobe low for all bits
	task automatic frame(input logic [63:0] bits, input int n,
		output logic [63:0] got);
		got = '0;
		latch_strobe = 1'b0;
		#10;
		for (int k = n - 1; k >= 0; k--) begin
			sdata_in = bits[k];
			#8 sclk = 1'b1;
			#12 got = {got[62:0], serial_out_pin};
			#4 sclk = 1'b0;
			#8;
		end
		latch_strobe = 1'b1;
		// released line shows the inverse so stale data never matches
		sdata_in = ~sdata_in;
		// gap well over six clocks lets the readback refresh
		#500;
	endtask
endmodule

// ==== sim/tb_serial_config_readback_chain.sv ====
// self-checking bench of the serial configuration port
// assumes scr_ctl_model drives the link at a 32 ns period
module tb_serial_config_readback_chain import scr_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	logic         clock;
	logic         rst_n;
	scr_apb_req_t req;
	scr_apb_rsp_t rsp;
	logic         sclk;
	logic         sdata_in;
	logic         latch_strobe;
	logic         serial_out_pin;
	scr_mix_t     mix;
	int           err_count;
	int           tests_run;
	logic [31:0]  rd;
	logic         er;
	logic [63:0]  got;

	scr_serial_port dut (
		.clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
		.sclk(sclk), .sdata_in(sdata_in), .latch_strobe(latch_strobe),
		.serial_out_pin(serial_out_pin), .mixer_ctl(mix)
	);

	scr_ctl_model ctl (
		.sclk(sclk), .sdata_in(sdata_in), .latch_strobe(latch_strobe),
		.serial_out_pin(serial_out_pin)
	);

	// 40 mhz system clock
	always #12.5 clock = ~clock;

	// ***************************************
	// helpers
	// ***************************************
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// apb master: hold request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		if (rsp.pready !== 1'b1) begin
			err_count++;
			$display("FAIL t=%0t apb answer missing", $time);
			summarize();
		end
	endtask

	// word loaded into register r during initialisation
	function automatic logic [31:0] wd(input logic [3:0] r);
		return {4'h3, r, 20'h00000, r};
	endfunction

	// ***************************************
	// scenarios
	// ***************************************
	task automatic t_reset();
		chk({27'h0, mix}, {27'h0, SCR_MIX_OFF, SCR_MIX_OFF, 1'b1});
		apb(1'b0, `SCR_CTRL_OFS, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, 12'h0fc, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("reset test done");
	endtask

	task automatic t_init();
		for (int r = 15; r >= 0; r--)
			ctl.frame({32'h0, wd(r[3:0])}, 32, got);
		apb(1'b0, `SCR_LAST_OFS, 32'h0);
		chk(rd, wd(4'h0));
		apb(1'b0, `SCR_STATUS_OFS, 32'h0);
		chk(rd, 32'h0010_0003);
		chk({27'h0, mix}, {27'h0, SCR_MIX_OFF, SCR_MIX_OFF, 1'b1});
		$display("init test done");
	endtask

	task automatic t_readback();
		ctl.frame(64'h0, 32, got);
		chk(got[31:0], wd(4'h3));
		apb(1'b0, `SCR_LAST_OFS, 32'h0);
		chk(rd, wd(4'h0));
		ctl.frame({32'h0, 32'h7000_0005}, 32, got);
		chk(got[31:0], wd(4'h3));
		ctl.frame(64'h0, 32, got);
		chk(got[31:0], wd(4'h7));
		$display("readback test done");
	endtask

	task automatic t_mixer();
		ctl.frame({32'h0, 32'h0000_000f}, 32, got);
		ctl.frame({32'h0, 32'h0000_002d}, 32, got);
		chk({27'h0, mix}, {27'h0, SCR_MIX_ON, SCR_MIX_OFF, 1'b1});
		ctl.frame({32'h0, 32'h0000_400f}, 32, got);
		ctl.frame({32'h0, 32'h0000_001d}, 32, got);
		chk({27'h0, mix}, {27'h0, SCR_MIX_STBY, SCR_MIX_ON, 1'b1});
		$display("mixer test done");
	endtask

	task automatic t_chain();
		ctl.frame({32'h0, 32'h0010_0006}, 32, got);
		ctl.frame({32'h5a5a_0c0c, 32'h0000_003d}, 64, got);
		chk(got[63:32], wd(4'h7));
		chk(got[31:0], 32'h5a5a_0c0c);
		chk({27'h0, mix}, {27'h0, SCR_MIX_ON, SCR_MIX_ON, 1'b1});
		// nop keeps this device, next word passes on
		ctl.frame({32'h0000_002d, 32'h0}, 64, got);
		chk(got[63:32], wd(4'h7));
		chk(got[31:0], 32'h0000_002d);
		chk({27'h0, mix}, {27'h0, SCR_MIX_ON, SCR_MIX_ON, 1'b1});
		ctl.frame({32'h0, 32'h0000_0006}, 32, got);
		apb(1'b0, `SCR_STATUS_OFS, 32'h0);
		chk({27'h0, rd[4:0]}, 32'h0000_0007);
		$display("chain test done");
	endtask

	task automatic t_refuse();
		ctl.frame({48'h0, 16'h000d}, 16, got);
		chk({27'h0, mix}, {27'h0, SCR_MIX_ON, SCR_MIX_ON, 1'b1});
		apb(1'b1, `SCR_CTRL_OFS, 32'h0);
		ctl.frame({32'h0, 32'h0000_000d}, 32, got);
		chk({27'h0, mix}, {27'h0, SCR_MIX_ON, SCR_MIX_ON, 1'b1});
		apb(1'b0, `SCR_CTRL_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `SCR_CTRL_OFS, 32'h1);
		$display("refusal test done");
	endtask

	// ***************************************
	// main sequence
	// ***************************************
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		req = '0;
		err_count = 0;
		tests_run = 0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (8) @(posedge clock);
		t_reset();
		t_init();
		t_readback();
		t_mixer();
		t_chain();
		t_refuse();
		summarize();
	end
endmodule
